// ---- bench/tb_fsr_regs.sv ----
// self-checking testbench for the fiber status and identifier register bank
// assumes fsr_regs on one 125 MHz clock with the plain read/write register port
module tb_fsr_regs;
  timeunit 1ns;
  timeprecision 1ps;

  // arbitrary identifier value
  localparam logic [15:0] ID_VAL = 16'h3c5a;

  logic        sys_clk_i      = 1'b0;
  logic        nrst_i         = 1'b0;
  logic        sw_rst_i       = 1'b0;
  logic [1:0]  mode_i         = 2'h0;
  logic        link_up_i      = 1'b0;
  logic        remote_fault_i = 1'b0;
  logic        an_done_i      = 1'b0;
  logic        an_enable_i    = 1'b0;
  logic        an_bypass_i    = 1'b0;
  logic [4:0]  addr_i         = 5'h00;
  logic [15:0] wdata_i        = 16'h0000;
  logic        wr_i           = 1'b0;
  logic        rd_i           = 1'b0;
  logic [15:0] rdata_o;
  logic        irq_o;
  int          err_count      = 0;
  int          tests_run      = 0;
  // model state: latches, settled pins, interrupt status and mask
  bit          flt, lnk, pf, pl, pa;
  bit   [2:0]  istat, imask;
  logic [1:0]  md             = 2'h0;
  logic [15:0] rv;
  logic [4:0]  pins;

  always #4 sys_clk_i = ~sys_clk_i;

  fsr_regs #(.OUI_HIGH_WORD(ID_VAL)) i_fsr_regs (
    .sys_clk_i      (sys_clk_i),
    .nrst_i         (nrst_i),
    .sw_rst_i       (sw_rst_i),
    .mode_i         (mode_i),
    .link_up_i      (link_up_i),
    .remote_fault_i (remote_fault_i),
    .an_done_i      (an_done_i),
    .an_enable_i    (an_enable_i),
    .an_bypass_i    (an_bypass_i),
    .addr_i         (addr_i),
    .wdata_i        (wdata_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .rdata_o        (rdata_o),
    .irq_o          (irq_o)
  );

  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : cmp16

  task automatic cmp_irq;
    tests_run++;
    if (irq_o !== (|(istat & imask))) begin
      err_count++;
      $display("[ERR] irq_o expected %b seen %b", |(istat & imask), irq_o);
    end
  endtask : cmp_irq

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    if (a == fsr_pkg::ADDR_IRQ_STAT) istat &= ~d[2:0];
    if (a == fsr_pkg::ADDR_IRQ_MASK) imask = d[2:0];
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [15:0] q);
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    q = rdata_o;
  endtask : rd

  function automatic logic [15:0] stat_exp();
    logic [15:0] e;
    e = 16'h0000;
    e[fsr_pkg::BIT_FX_FULL]  = (md == fsr_pkg::MODE_FX);
    e[fsr_pkg::BIT_FX_HALF]  = (md == fsr_pkg::MODE_FX);
    e[fsr_pkg::BIT_EXT_STAT] = 1'b1;
    e[fsr_pkg::BIT_SHORT_FR] = 1'b1;
    e[fsr_pkg::BIT_AN_DONE]  = pa;
    e[fsr_pkg::BIT_RFAULT]   = flt && md != fsr_pkg::MODE_SGMII;
    e[fsr_pkg::BIT_AN_ABLE]  = (md != fsr_pkg::MODE_FX);
    e[fsr_pkg::BIT_LINK]     = lnk;
    e[fsr_pkg::BIT_EXT_CAP]  = 1'b1;
    return e;
  endfunction : stat_exp

  // a status read re-arms both latches to the present condition
  task automatic rd_stat;
    rd(fsr_pkg::ADDR_STATUS, rv);
    cmp16("status", stat_exp(), rv);
    flt = pf && md != fsr_pkg::MODE_SGMII;
    lnk = pl;
  endtask : rd_stat

  // two status reads with no gap, the second gives the present condition
  task automatic rd_stat2;
    @(posedge sys_clk_i);
    rd_i   <= 1'b1;
    addr_i <= fsr_pkg::ADDR_STATUS;
    @(posedge sys_clk_i);
    #1;
    cmp16("status", stat_exp(), rdata_o);
    flt = pf && md != fsr_pkg::MODE_SGMII;
    lnk = pl;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    cmp16("status", stat_exp(), rdata_o);
    flt = pf && md != fsr_pkg::MODE_SGMII;
    lnk = pl;
  endtask : rd_stat2

  // apply mode and pins, let them pass the synchroniser, update the model
  task automatic drive(input logic [1:0] m, input logic [4:0] p);
    bit an;
    bit fc;
    an = p[fsr_pkg::PIN_AN_END] && p[fsr_pkg::PIN_AN_ENA] && !p[fsr_pkg::PIN_AN_BYP];
    // fault events only count outside sgmii mode
    fc = p[fsr_pkg::PIN_RFAULT] && m != fsr_pkg::MODE_SGMII;
    @(posedge sys_clk_i);
    mode_i         <= m;
    link_up_i      <= p[fsr_pkg::PIN_LINK];
    remote_fault_i <= p[fsr_pkg::PIN_RFAULT];
    an_done_i      <= p[fsr_pkg::PIN_AN_END];
    an_enable_i    <= p[fsr_pkg::PIN_AN_ENA];
    an_bypass_i    <= p[fsr_pkg::PIN_AN_BYP];
    repeat (5) @(posedge sys_clk_i);
    md = m;
    if (fc && !pf) istat[fsr_pkg::IRQ_RFAULT] = 1'b1;
    if (!p[fsr_pkg::PIN_LINK] && pl) istat[fsr_pkg::IRQ_LINKLOST] = 1'b1;
    if (an && !pa) istat[fsr_pkg::IRQ_AN_DONE] = 1'b1;
    pf = fc;
    pl = p[fsr_pkg::PIN_LINK];
    pa = an;
    if (pf && md != fsr_pkg::MODE_SGMII) flt = 1'b1;
    if (!pl) lnk = 1'b0;
  endtask : drive

  initial begin
    void'($urandom(32'hd823));
    repeat (10) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      drive(2'(m), 5'h00);
      rd_stat();
    end
    rd(fsr_pkg::ADDR_ID_HIGH, rv);
    cmp16("id", ID_VAL, rv);
    wr(fsr_pkg::ADDR_ID_HIGH, 16'hffff);
    wr(fsr_pkg::ADDR_STATUS, 16'hffff);
    rd(fsr_pkg::ADDR_ID_HIGH, rv);
    cmp16("id", ID_VAL, rv);
    rd_stat();
    rd(5'h1f, rv);
    cmp16("unmapped", 16'h0000, rv);
    // link up, loss, return: back-to-back reads give present link
    drive(2'h1, 5'h01);
    rd_stat();
    rd_stat();
    drive(2'h1, 5'h00);
    drive(2'h1, 5'h01);
    rd_stat2();
    // fault latch, and fault hidden in SGMII
    drive(2'h1, 5'h03);
    drive(2'h1, 5'h01);
    rd_stat();
    rd_stat();
    drive(2'h2, 5'h03);
    rd_stat();
    drive(2'h2, 5'h01);
    drive(2'h1, 5'h01);
    rd_stat();
    // completion set only when enabled and not bypassed
    drive(2'h1, 5'h0d);
    rd_stat();
    drive(2'h1, 5'h1d);
    rd_stat();
    drive(2'h1, 5'h05);
    rd_stat();
    drive(2'h1, 5'h01);
    // interrupt status, mask and write-one-to-clear
    rd(fsr_pkg::ADDR_IRQ_STAT, rv);
    cmp16("irq_stat", {13'h0, istat}, rv);
    cmp_irq();
    wr(fsr_pkg::ADDR_IRQ_MASK, 16'h0002);
    rd(fsr_pkg::ADDR_IRQ_MASK, rv);
    cmp16("irq_mask", {13'h0, imask}, rv);
    cmp_irq();
    wr(fsr_pkg::ADDR_IRQ_STAT, 16'h0002);
    rd(fsr_pkg::ADDR_IRQ_STAT, rv);
    cmp16("irq_stat", {13'h0, istat}, rv);
    cmp_irq();
    wr(fsr_pkg::ADDR_IRQ_STAT, 16'hffff);
    wr(fsr_pkg::ADDR_IRQ_MASK, 16'h0006);
    rd(fsr_pkg::ADDR_IRQ_STAT, rv);
    cmp16("irq_stat", {13'h0, istat}, rv);
    // soft reset clears the link latch while link stays up
    rd_stat();
    @(posedge sys_clk_i);
    sw_rst_i <= 1'b1;
    @(posedge sys_clk_i);
    sw_rst_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    lnk = 1'b0;
    flt = 1'b0;
    rd_stat2();
    // random pins first, then random mode
    for (int i = 0; i < 40; i++) begin
      pins = 5'($urandom);
      drive(md, pins);
      drive(2'($urandom), pins);
      rd_stat();
      cmp_irq();
    end
    results();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_count++;
    results();
  end

endmodule : tb_fsr_regs

// ---- hw/fsr_latch_bit.sv ----
// one latching status bit, latch-high or latch-low by parameter
// assumes cond_i is synchronous; rd_i pulses once per status read
module fsr_latch_bit #(
  parameter logic ACTIVE = 1'b1,
  parameter logic RST    = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic nrst_i,
  // control
  input  wire logic cond_i,
  input  wire logic rd_i,
  input  wire logic clr_i,
  // state
  output logic      q_o
);

  // a new event beats both the clear and the re-arm
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q_o <= RST;
    end else if (cond_i == ACTIVE) begin
      q_o <= ACTIVE;
    end else if (clr_i) begin
      q_o <= RST;
    end else if (rd_i) begin
      q_o <= cond_i;
    end
  end

endmodule : fsr_latch_bit

// ---- hw/fsr_regs.sv ----
// fiber status and identifier register bank with event interrupt
// assumes fiber pins are asynchronous levels, mode and soft reset come
// from logic on sys_clk_i, and the master never reads and writes at once
module fsr_regs #(
  // arbitrary identifier value
  parameter logic [15:0] OUI_HIGH_WORD = 16'h5a3c
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        nrst_i,
  // soft reset and mode
  input  wire logic        sw_rst_i,
  input  wire logic [1:0]  mode_i,
  // fiber pcs levels
  input  wire logic        link_up_i,
  input  wire logic        remote_fault_i,
  input  wire logic        an_done_i,
  input  wire logic        an_enable_i,
  input  wire logic        an_bypass_i,
  // register port
  input  wire logic [4:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // interrupt
  output logic             irq_o
);

  logic [fsr_pkg::PIN_W-1:0] pins_raw;
  logic [fsr_pkg::PIN_W-1:0] pins_s;
  logic                      link_s;
  logic                      fault_s;
  logic                      an_end_s;
  logic                      an_ena_s;
  logic                      an_byp_s;
  logic                      is_fx;
  logic                      is_sgmii;
  logic                      fault_cond;
  logic                      rd_status;
  logic                      rd_stat_q;
  logic                      rd_id_q;
  logic                      fault_lat;
  logic                      link_lat;
  logic                      an_cmpl_reg;
  logic                      an_cmpl_next;
  logic                      fault_prev_reg;
  logic                      link_prev_reg;
  logic                      an_prev_reg;
  logic [fsr_pkg::IRQ_W-1:0] ev;
  logic [fsr_pkg::IRQ_W-1:0] ists_reg;
  logic [fsr_pkg::IRQ_W-1:0] ists_next;
  logic [fsr_pkg::IRQ_W-1:0] imask_reg;
  logic [15:0]               status_word;
  logic [15:0]               rdata_next;

  // pin synchronisation
  always_comb begin
    pins_raw                      = '0;
    pins_raw[fsr_pkg::PIN_LINK]   = link_up_i;
    pins_raw[fsr_pkg::PIN_RFAULT] = remote_fault_i;
    pins_raw[fsr_pkg::PIN_AN_END] = an_done_i;
    pins_raw[fsr_pkg::PIN_AN_ENA] = an_enable_i;
    pins_raw[fsr_pkg::PIN_AN_BYP] = an_bypass_i;
  end

  fsr_sync2 #(
    .WIDTH (fsr_pkg::PIN_W)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .async_i   (pins_raw),
    .sync_o    (pins_s)
  );

  assign link_s   = pins_s[fsr_pkg::PIN_LINK];
  assign fault_s  = pins_s[fsr_pkg::PIN_RFAULT];
  assign an_end_s = pins_s[fsr_pkg::PIN_AN_END];
  assign an_ena_s = pins_s[fsr_pkg::PIN_AN_ENA];
  assign an_byp_s = pins_s[fsr_pkg::PIN_AN_BYP];

  // mode decode
  assign is_fx      = (mode_i == fsr_pkg::MODE_FX);
  assign is_sgmii   = (mode_i == fsr_pkg::MODE_SGMII);
  assign fault_cond = fault_s & ~is_sgmii;
  assign rd_status  = rd_i & (addr_i == fsr_pkg::ADDR_STATUS);

  // latching bits
  fsr_latch_bit #(
    .ACTIVE (1'b1),
    .RST    (1'b0)
  ) u_fault_lat (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .cond_i    (fault_cond),
    .rd_i      (rd_status),
    .clr_i     (sw_rst_i),
    .q_o       (fault_lat)
  );

  fsr_latch_bit #(
    .ACTIVE (1'b0),
    .RST    (1'b0)
  ) u_link_lat (
    .sys_clk_i (sys_clk_i),
    .nrst_i    (nrst_i),
    .cond_i    (link_s),
    .rd_i      (rd_status),
    .clr_i     (sw_rst_i),
    .q_o       (link_lat)
  );

  // auto-negotiation complete
  assign an_cmpl_next = an_end_s & an_ena_s & ~an_byp_s;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      an_cmpl_reg <= 1'b0;
    end else if (sw_rst_i) begin
      an_cmpl_reg <= 1'b0;
    end else begin
      an_cmpl_reg <= an_cmpl_next;
    end
  end

  // status word assembly
  always_comb begin
    status_word                                        = '0;
    status_word[fsr_pkg::BIT_T4]                       = fsr_pkg::T4_ABLE;
    status_word[fsr_pkg::BIT_FX_FULL]                  = is_fx;
    status_word[fsr_pkg::BIT_FX_HALF]                  = is_fx;
    status_word[fsr_pkg::BIT_NONE_HI:fsr_pkg::BIT_NONE_LO] = fsr_pkg::NONE_ABLE_VAL;
    status_word[fsr_pkg::BIT_EXT_STAT]                 = fsr_pkg::EXT_STAT_VAL;
    status_word[fsr_pkg::BIT_RSVD_HI]                  = 1'b0;
    status_word[fsr_pkg::BIT_SHORT_FR]                 = fsr_pkg::SHORT_FR_VAL;
    status_word[fsr_pkg::BIT_AN_DONE]                  = an_cmpl_reg;
    status_word[fsr_pkg::BIT_RFAULT]                   = fault_lat & ~is_sgmii;
    status_word[fsr_pkg::BIT_AN_ABLE]                  = ~is_fx;
    status_word[fsr_pkg::BIT_LINK]                     = link_lat;
    status_word[fsr_pkg::BIT_RSVD_LO]                  = 1'b0;
    status_word[fsr_pkg::BIT_EXT_CAP]                  = fsr_pkg::EXT_CAP_VAL;
  end

  // event detection for interrupts
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fault_prev_reg <= 1'b0;
      link_prev_reg  <= 1'b0;
      an_prev_reg    <= 1'b0;
    end else begin
      fault_prev_reg <= fault_cond;
      link_prev_reg  <= link_s;
      an_prev_reg    <= an_cmpl_reg;
    end
  end

  always_comb begin
    ev                       = '0;
    ev[fsr_pkg::IRQ_RFAULT]   = fault_cond & ~fault_prev_reg;
    ev[fsr_pkg::IRQ_LINKLOST] = ~link_s & link_prev_reg;
    ev[fsr_pkg::IRQ_AN_DONE]  = an_cmpl_reg & ~an_prev_reg;
  end

  // sticky status, write one to clear, a fresh event wins
  always_comb begin
    ists_next = ists_reg;
    if (wr_i && addr_i == fsr_pkg::ADDR_IRQ_STAT) begin
      ists_next = ists_reg & ~wdata_i[fsr_pkg::IRQ_W-1:0];
    end
    ists_next = ists_next | ev;
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ists_reg <= fsr_pkg::IRQ_RST;
    end else begin
      ists_reg <= ists_next;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      imask_reg <= fsr_pkg::IRQ_RST;
    end else if (wr_i && addr_i == fsr_pkg::ADDR_IRQ_MASK) begin
      imask_reg <= wdata_i[fsr_pkg::IRQ_W-1:0];
    end
  end

  assign irq_o = |(ists_reg & imask_reg);

  // read mux, data one cycle after the strobe
  always_comb begin
    rdata_next = '0;
    case (addr_i)
      fsr_pkg::ADDR_STATUS:   rdata_next = status_word;
      fsr_pkg::ADDR_ID_HIGH:  rdata_next = OUI_HIGH_WORD;
      fsr_pkg::ADDR_IRQ_STAT: rdata_next = {13'h0000, ists_reg};
      fsr_pkg::ADDR_IRQ_MASK: rdata_next = {13'h0000, imask_reg};
      default:                rdata_next = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= fsr_pkg::RDATA_RST;
    end else if (rd_i) begin
      rdata_o <= rdata_next;
    end else begin
      rdata_o <= fsr_pkg::RDATA_RST;
    end
  end

  // read tracking for checks
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_stat_q <= 1'b0;
      rd_id_q   <= 1'b0;
    end else begin
      rd_stat_q <= rd_status;
      rd_id_q   <= rd_i & (addr_i == fsr_pkg::ADDR_ID_HIGH);
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);

  a_t4_low: assert property (rd_stat_q |-> !rdata_o[15])
    else $error("t4 ability bit set");

  a_fx_ability: assert property (
    rd_stat_q |-> rdata_o[14:13] == {2{$past(mode_i) == fsr_pkg::MODE_FX}})
    else $error("100 Mbps fiber ability bits wrong for mode");

  a_unused_zero: assert property (rd_stat_q |-> rdata_o[12:9] == 4'h0)
    else $error("unsupported ability bits not zero");

  a_ext_status: assert property (rd_stat_q |-> rdata_o[8])
    else $error("extended status bit clear");

  a_short_frame: assert property (rd_stat_q |-> rdata_o[6])
    else $error("short frame accept bit clear");

  a_an_complete: assert property (
    an_cmpl_reg |-> $past(an_ena_s) && !$past(an_byp_s) && $past(an_end_s))
    else $error("auto-negotiation complete without cause");

  a_fault_latch: assert property (fault_cond |=> fault_lat [*1] ##0 1'b1)
    else $error("remote fault not latched");

  a_fault_sgmii: assert property (
    rd_stat_q && $past(mode_i) == fsr_pkg::MODE_SGMII |-> !rdata_o[4])
    else $error("remote fault shown in sgmii mode");

  a_an_ability: assert property (
    rd_stat_q |-> rdata_o[3] == ($past(mode_i) != fsr_pkg::MODE_FX))
    else $error("auto-negotiation ability wrong for mode");

  a_link_low: assert property (!link_s ##1 rd_status |=> !rdata_o[2])
    else $error("lost link not reported on next read");

  a_link_rearm: assert property (
    rd_status && link_s ##1 (rd_status && link_s) |=> rdata_o[2])
    else $error("second back-to-back read misses present link");

  a_fault_rearm: assert property (rd_status && !fault_cond |=> !fault_lat)
    else $error("remote fault latch not re-armed by read");

  a_fixed_bits: assert property (
    rd_stat_q |-> rdata_o[0] && !rdata_o[7] && !rdata_o[1])
    else $error("capability or reserved bits wrong");

  a_id_word: assert property (rd_id_q |-> rdata_o == OUI_HIGH_WORD)
    else $error("identifier word wrong");

  a_irq_sticky: assert property (
    ev[fsr_pkg::IRQ_LINKLOST] |=> ists_reg[fsr_pkg::IRQ_LINKLOST] ##1
    (ists_reg[fsr_pkg::IRQ_LINKLOST] || $past(wr_i)))
    else $error("link loss event not held");

  c_link_twice: cover property (!link_s ##1 rd_status ##1 rd_status);
  c_fault_read: cover property (fault_lat && rd_status);
  c_an_done: cover property ($rose(an_cmpl_reg));
  c_irq: cover property ($rose(irq_o));

endmodule : fsr_regs

// ---- hw/fsr_sync2.sv ----
// two-stage synchroniser for a bundle of level inputs
// assumes inputs are levels from outside the sys_clk_i domain
module fsr_sync2 #(
  parameter int WIDTH = 5
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             nrst_i,
  // levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule : fsr_sync2

// ---- shared/fsr_pkg.sv ----
// constants for the fiber status and identifier register bank
// assumes a 16-bit management data path and a 5-bit register address
package fsr_pkg;

  // register addresses
  localparam logic [4:0] ADDR_STATUS   = 5'h01;
  localparam logic [4:0] ADDR_ID_HIGH  = 5'h02;
  localparam logic [4:0] ADDR_IRQ_STAT = 5'h10;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h11;

  // status word bit positions
  localparam int BIT_T4       = 15;
  localparam int BIT_FX_FULL  = 14;
  localparam int BIT_FX_HALF  = 13;
  localparam int BIT_NONE_HI  = 12;
  localparam int BIT_NONE_LO  = 9;
  localparam int BIT_EXT_STAT = 8;
  localparam int BIT_RSVD_HI  = 7;
  localparam int BIT_SHORT_FR = 6;
  localparam int BIT_AN_DONE  = 5;
  localparam int BIT_RFAULT   = 4;
  localparam int BIT_AN_ABLE  = 3;
  localparam int BIT_LINK     = 2;
  localparam int BIT_RSVD_LO  = 1;
  localparam int BIT_EXT_CAP  = 0;

  // fixed status values
  localparam logic       T4_ABLE       = 1'b0;
  localparam logic       EXT_STAT_VAL  = 1'b1;
  localparam logic       SHORT_FR_VAL  = 1'b1;
  localparam logic       EXT_CAP_VAL   = 1'b1;
  localparam logic [3:0] NONE_ABLE_VAL = 4'h0;

  // fiber mode field encodings
  localparam logic [1:0] MODE_FX    = 2'h0;
  localparam logic [1:0] MODE_BASEX = 2'h1;
  localparam logic [1:0] MODE_SGMII = 2'h2;

  // interrupt status / mask layout
  localparam int         IRQ_W        = 3;
  localparam int         IRQ_RFAULT   = 0;
  localparam int         IRQ_LINKLOST = 1;
  localparam int         IRQ_AN_DONE  = 2;
  localparam logic [2:0] IRQ_RST      = 3'h0;

  // pin bundle layout
  localparam int PIN_W      = 5;
  localparam int PIN_LINK   = 0;
  localparam int PIN_RFAULT = 1;
  localparam int PIN_AN_END = 2;
  localparam int PIN_AN_ENA = 3;
  localparam int PIN_AN_BYP = 4;

  localparam logic [15:0] RDATA_RST = 16'h0000;

endpackage : fsr_pkg
